// ===== design/mpll_cfg.svh
`ifndef MPLL_CFG_SVH
`define MPLL_CFG_SVH

`define MPLL_INT_W 7
`define MPLL_FRAC_W 2
`define MPLL_MULT_W 9
`define MPLL_DIV_W 6
`define MPLL_SYNC_W 4
`define MPLL_IN_REF 0
`define MPLL_IN_AUX 1
`define MPLL_IN_FAST 2
`define MPLL_IN_SLOW 3
`define MPLL_PER_W 16
`define MPLL_PER_MAX 16'hffff
`define MPLL_ACC_W 19
`define MPLL_CLK_NS 10
`define MPLL_SETTLE_NS 20000
`define MPLL_SETTLE_CYC ((`MPLL_SETTLE_NS + `MPLL_CLK_NS - 1) / `MPLL_CLK_NS)
`define MPLL_CNT_W 12
`define MPLL_MCD_W 4
`define MPLL_MCD_LIMIT 4'h8
`define MPLL_PLL_MIN_MHZ 150
`define MPLL_PLL_MAX_MHZ 300

`endif

// ===== design/mpll_pkg.sv
package mpll_pkg;

  typedef enum logic [1:0] {
    mpll_st_bypass = 2'b00,
    mpll_st_settle = 2'b01,
    mpll_st_locked = 2'b10
  } mpll_state_t;

endpackage : mpll_pkg

// ===== design/mpll_nco_if.sv
`timescale 1ns/1ps
`include "mpll_cfg.svh"

interface mpll_nco_if;
  logic ref_tick;
  logic [`MPLL_MULT_W-1:0] mult;
  logic pll_tick;

  modport core
  (
    input ref_tick,
    input mult,
    output pll_tick
  );

  modport ctrl
  (
    output ref_tick,
    output mult,
    input pll_tick
  );
endinterface : mpll_nco_if

// ===== design/mpll_sync.sv
`timescale 1ns/1ps
`include "mpll_cfg.svh"

module mpll_sync
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [`MPLL_SYNC_W-1:0] d_async,
  output logic [`MPLL_SYNC_W-1:0] q
);
  logic [`MPLL_SYNC_W-1:0] meta_q;

  // The first stage feeds only the second stage.
  genvar i;
  generate
    for (i = 0; i < `MPLL_SYNC_W; i++)
    begin : g_bit
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          meta_q[i] <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= d_async[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : mpll_sync

// ===== design/mpll_nco.sv
`timescale 1ns/1ps
`include "mpll_cfg.svh"

module mpll_nco
(
  input wire logic clock,
  input wire logic rst,
  mpll_nco_if.core nco
);
  logic [`MPLL_PER_W-1:0] per_cnt_q;
  logic [`MPLL_PER_W-1:0] period_q;
  logic [`MPLL_ACC_W-1:0] acc_q;
  logic [`MPLL_ACC_W-1:0] acc_sum;
  logic [`MPLL_ACC_W-1:0] acc_left;
  logic [`MPLL_ACC_W-1:0] acc_d;
  logic [`MPLL_ACC_W-1:0] limit;
  logic wrap;
  logic tick_q;

  // Multiplier is held in quarters, so the reference period is scaled by four.
  assign limit = {1'b0, period_q, 2'b00};
  assign acc_sum = acc_q + {{(`MPLL_ACC_W-`MPLL_MULT_W){1'b0}}, nco.mult};
  assign wrap = (period_q != '0) && (acc_sum >= limit);
  assign nco.pll_tick = tick_q;
  assign acc_left = acc_sum - limit;
  // Clamping keeps a multiplier above the cap from running the accumulator into overflow.
  assign acc_d = (period_q == '0) ? '0
    : (!wrap ? acc_sum : ((acc_left >= limit) ? limit : acc_left));

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      per_cnt_q <= '0;
      period_q <= '0;
    end
    else if (nco.ref_tick)
    begin
      per_cnt_q <= '0;
      period_q <= per_cnt_q + 16'h0001;
    end
    else if (per_cnt_q != `MPLL_PER_MAX)
    begin
      per_cnt_q <= per_cnt_q + 16'h0001;
    end
  end

  // Output rate is mult/4 times the reference rate, capped at one tick per clock.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tick_q <= wrap; // R5
    end
  end

  property p_nco_period;
    @(posedge clock) disable iff (rst)
    nco.ref_tick |=> (per_cnt_q == '0) && (period_q == $past(per_cnt_q) + 16'h0001);
  endproperty
  a_nco_period: assert property (p_nco_period) else $error("reference period not captured"); // R5

  property p_nco_idle;
    @(posedge clock) disable iff (rst)
    (nco.mult == '0) && (acc_q == '0) |=> !tick_q;
  endproperty
  a_nco_idle: assert property (p_nco_idle) else $error("tick without multiplier"); // R5
endmodule : mpll_nco

// ===== design/mpll_top.sv
`timescale 1ns/1ps
`include "mpll_cfg.svh"

// Behaviour
// [R1] Internal oscillator clocks feed low-power use only; the fast one also drives missing-clock detection.
// [R2] Fast internal clock drives missing-clock detection.
// [R3] Auxiliary input goes only to USB PLL, CAN.
// [R4] PLL reference comes from primary clock pin.
// [R5] PLL multiplies by integer plus fractional factor.
// [R6] Software keeps PLL output within 150-300 MHz.
// [R7] PLL output halved before the source mux.
// [R8] Mux picks halved PLL or raw reference.
// [R9] Integer multiplier zero selects bypass mode.
// [R10] Mux output divided by system divider select.
// [R11] Seven-bit integer field, code n multiplies n.
// [R12] Stay on bypass until PLL settles after change.
module mpll_top
(
  input wire logic clock,
  input wire logic rst,
  input wire logic primary_clk_pin,
  input wire logic aux_clk_input,
  input wire logic internal_fast_osc_clk,
  input wire logic internal_slow_osc_clk,
  input wire logic [`MPLL_INT_W-1:0] main_pll_int_mult,
  input wire logic [`MPLL_FRAC_W-1:0] main_pll_frac_mult,
  input wire logic [`MPLL_DIV_W-1:0] sys_div_select,
  output logic divided_sys_clk,
  output logic osc_ref_clk,
  output logic pll_locked,
  output logic missing_clk,
  output logic lp_fast_clk,
  output logic lp_slow_clk,
  output logic usb_pll_ref_clk,
  output logic can_clk
);
  logic [`MPLL_SYNC_W-1:0] pins_s;
  logic ref_prev_q;
  logic fast_prev_q;
  logic ref_tick;
  logic fast_tick;
  logic [`MPLL_MULT_W-1:0] mult_now;
  logic [`MPLL_MULT_W-1:0] mult_q;
  logic mult_chg;
  mpll_pkg::mpll_state_t st_q;
  mpll_pkg::mpll_state_t st_d;
  logic [`MPLL_CNT_W-1:0] settle_q;
  logic [`MPLL_CNT_W-1:0] settle_d;
  logic use_pll;
  logic half_q;
  logic half_tick;
  logic mux_tick;
  logic [`MPLL_DIV_W-1:0] div_q;
  logic div_hit;
  logic sys_tick_q;
  logic [`MPLL_MCD_W-1:0] mcd_q;
  logic mcd_set;
  logic missing_q;
  logic lock_q;
  logic ref_q;
  logic lp_fast_q;
  logic lp_slow_q;
  logic usb_q;
  logic can_q;

  mpll_nco_if nco_bus ();

  function automatic logic mpll_is_bypass(input logic [`MPLL_INT_W-1:0] imult);
    mpll_is_bypass = (imult == '0);
  endfunction : mpll_is_bypass

  mpll_sync u_sync
  (
    .clock(clock),
    .rst(rst),
    .d_async({internal_slow_osc_clk, internal_fast_osc_clk, aux_clk_input, primary_clk_pin}),
    .q(pins_s)
  );

  mpll_nco u_nco
  (
    .clock(clock),
    .rst(rst),
    .nco(nco_bus.core)
  );

  // Edge detectors look at the second synchroniser stage only.
  assign ref_tick = pins_s[`MPLL_IN_REF] & ~ref_prev_q; // R4
  assign fast_tick = pins_s[`MPLL_IN_FAST] & ~fast_prev_q;

  // The 7-bit integer code is used as the multiplier itself; the fraction is quarters.
  assign mult_now = {main_pll_int_mult, main_pll_frac_mult}; // R11
  assign mult_chg = (mult_now != mult_q);
  assign nco_bus.ref_tick = ref_tick; // R4
  assign nco_bus.mult = mult_q; // R5

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ref_prev_q <= 1'b0;
      fast_prev_q <= 1'b0;
      mult_q <= '0;
    end
    else
    begin
      ref_prev_q <= pins_s[`MPLL_IN_REF];
      fast_prev_q <= pins_s[`MPLL_IN_FAST];
      mult_q <= mult_now;
    end
  end

  // Any change that leaves the integer code nonzero restarts the settle time, so a half-locked loop never reaches the divider.
  always_comb
  begin
    st_d = st_q;
    settle_d = settle_q;
    if (mpll_is_bypass(main_pll_int_mult))
    begin
      st_d = mpll_pkg::mpll_st_bypass; // R9
      settle_d = '0;
    end
    else if (mult_chg)
    begin
      st_d = mpll_pkg::mpll_st_settle; // R12
      settle_d = `MPLL_CNT_W'(`MPLL_SETTLE_CYC - 1);
    end
    else
    begin
      unique case (st_q)
        mpll_pkg::mpll_st_bypass:
        begin
          st_d = mpll_pkg::mpll_st_bypass;
        end
        mpll_pkg::mpll_st_settle:
        begin
          if (settle_q == '0)
          begin
            st_d = mpll_pkg::mpll_st_locked; // R12
          end
          else
          begin
            settle_d = settle_q - 12'h001;
          end
        end
        mpll_pkg::mpll_st_locked:
        begin
          st_d = mpll_pkg::mpll_st_locked;
        end
        default:
        begin
          st_d = mpll_pkg::mpll_st_bypass;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q <= mpll_pkg::mpll_st_bypass;
      settle_q <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      settle_q <= settle_d;
      lock_q <= (st_d == mpll_pkg::mpll_st_locked);
    end
  end

  assign use_pll = (st_q == mpll_pkg::mpll_st_locked);
  assign half_tick = nco_bus.pll_tick & half_q; // R7
  assign mux_tick = use_pll ? half_tick : ref_tick; // R8
  // Comparing with >= keeps a lowered select from letting the count run past it.
  assign div_hit = mux_tick && (div_q >= sys_div_select); // R10
  assign mcd_set = fast_tick && (mcd_q == `MPLL_MCD_LIMIT - 4'h1); // R2

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      half_q <= 1'b0;
      div_q <= '0;
      sys_tick_q <= 1'b0;
    end
    else
    begin
      if (nco_bus.pll_tick)
      begin
        half_q <= ~half_q; // R7
      end
      if (div_hit)
      begin
        div_q <= '0;
      end
      else if (mux_tick)
      begin
        div_q <= div_q + 6'h01;
      end
      sys_tick_q <= div_hit; // R10
    end
  end

  // A reference edge clears the flag, but a detection in that cycle wins.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mcd_q <= '0;
      missing_q <= 1'b0;
    end
    else
    begin
      if (ref_tick)
      begin
        mcd_q <= '0;
      end
      else if (fast_tick && (mcd_q != `MPLL_MCD_LIMIT))
      begin
        mcd_q <= mcd_q + 4'h1;
      end
      missing_q <= mcd_set | (missing_q & ~ref_tick); // R2
    end
  end

  // The internal and auxiliary clocks leave only on their dedicated outputs.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ref_q <= 1'b0;
      lp_fast_q <= 1'b0;
      lp_slow_q <= 1'b0;
      usb_q <= 1'b0;
      can_q <= 1'b0;
    end
    else
    begin
      ref_q <= pins_s[`MPLL_IN_REF];
      lp_fast_q <= pins_s[`MPLL_IN_FAST]; // R1
      lp_slow_q <= pins_s[`MPLL_IN_SLOW]; // R1
      usb_q <= pins_s[`MPLL_IN_AUX]; // R3
      can_q <= pins_s[`MPLL_IN_AUX]; // R3
    end
  end

  assign divided_sys_clk = sys_tick_q;
  assign osc_ref_clk = ref_q;
  assign pll_locked = lock_q;
  assign missing_clk = missing_q;
  assign lp_fast_clk = lp_fast_q;
  assign lp_slow_clk = lp_slow_q;
  assign usb_pll_ref_clk = usb_q;
  assign can_clk = can_q;

  property p_bypass_zero;
    @(posedge clock) disable iff (rst)
    mpll_is_bypass(main_pll_int_mult) |=> !pll_locked && (st_q == mpll_pkg::mpll_st_bypass);
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("zero multiplier not bypassed"); // R9

  property p_mux_ref;
    @(posedge clock) disable iff (rst)
    !use_pll |-> (mux_tick == ref_tick);
  endproperty
  a_mux_ref: assert property (p_mux_ref) else $error("bypass mux not on reference"); // R8

  property p_mux_pll;
    @(posedge clock) disable iff (rst)
    use_pll && mux_tick |-> nco_bus.pll_tick && half_q;
  endproperty
  a_mux_pll: assert property (p_mux_pll) else $error("locked mux not on halved loop"); // R7

  property p_half;
    @(posedge clock) disable iff (rst)
    half_tick |=> !half_q && !half_tick;
  endproperty
  a_half: assert property (p_half) else $error("halver passed two loop ticks"); // R7

  property p_settle;
    @(posedge clock) disable iff (rst)
    mult_chg && !mpll_is_bypass(main_pll_int_mult)
      |=> (!use_pll && (mux_tick == ref_tick)) [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("loop used before settling"); // R12

  property p_div;
    @(posedge clock) disable iff (rst)
    mux_tick && (div_q < sys_div_select) |=> !divided_sys_clk && (div_q == $past(div_q) + 6'h01);
  endproperty
  a_div: assert property (p_div) else $error("divider fired early"); // R10

  property p_div_hit;
    @(posedge clock) disable iff (rst)
    mux_tick && (div_q >= sys_div_select) |=> divided_sys_clk && (div_q == '0);
  endproperty
  a_div_hit: assert property (p_div_hit) else $error("divider missed terminal count"); // R10

  property p_mcd;
    @(posedge clock) disable iff (rst)
    mcd_set |=> missing_clk ##1 (missing_clk || $past(ref_tick));
  endproperty
  a_mcd: assert property (p_mcd) else $error("missing clock not flagged"); // R2

  property p_aux;
    @(posedge clock) disable iff (rst)
    ##1 (usb_pll_ref_clk == $past(pins_s[`MPLL_IN_AUX])) && (can_clk == usb_pll_ref_clk);
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary clock misrouted"); // R3

  property p_lp;
    @(posedge clock) disable iff (rst)
    ##1 (lp_fast_clk == $past(pins_s[`MPLL_IN_FAST]))
      && (lp_slow_clk == $past(pins_s[`MPLL_IN_SLOW]));
  endproperty
  a_lp: assert property (p_lp) else $error("low-power clock mismatch"); // R1
endmodule : mpll_top

// ===== dv/main_pll_clock_generation_test.sv
`timescale 1ns/1ps
`include "mpll_cfg.svh"

module main_pll_clock_generation_test;
  logic clock;
  logic rst;
  logic primary_clk_pin;
  logic aux_clk_input;
  logic internal_fast_osc_clk;
  logic internal_slow_osc_clk;
  logic [`MPLL_INT_W-1:0] main_pll_int_mult;
  logic [`MPLL_FRAC_W-1:0] main_pll_frac_mult;
  logic [`MPLL_DIV_W-1:0] sys_div_select;
  logic divided_sys_clk;
  logic osc_ref_clk;
  logic pll_locked;
  logic missing_clk;
  logic lp_fast_clk;
  logic lp_slow_clk;
  logic usb_pll_ref_clk;
  logic can_clk;
  logic ref_run;
  logic fast_run;
  int bad_count;
  int n_checks;
  int cycles;
  int ref_cnt;
  int fast_cnt;
  int t0;
  int c;

  mpll_top u_mpll_top
  (
    .clock,
    .rst,
    .primary_clk_pin,
    .aux_clk_input,
    .internal_fast_osc_clk,
    .internal_slow_osc_clk,
    .main_pll_int_mult,
    .main_pll_frac_mult,
    .sys_div_select,
    .divided_sys_clk,
    .osc_ref_clk,
    .pll_locked,
    .missing_clk,
    .lp_fast_clk,
    .lp_slow_clk,
    .usb_pll_ref_clk,
    .can_clk
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Reference pin toggles every 4 cycles, the fast oscillator every 2, both on the falling edge.
  always @(negedge clock)
  begin
    if (ref_run)
    begin
      ref_cnt = ref_cnt + 1;
      if (ref_cnt == 4)
      begin
        ref_cnt = 0;
        primary_clk_pin = ~primary_clk_pin;
      end
    end
    if (fast_run)
    begin
      fast_cnt = fast_cnt + 1;
      if (fast_cnt == 2)
      begin
        fast_cnt = 0;
        internal_fast_osc_clk = ~internal_fast_osc_clk;
      end
    end
  end

  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_num(input string name, input int exp, input int got, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_num

  // Cycles from one output pulse to the n-th one after it.
  task automatic span(input int n, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while (divided_sys_clk !== 1'b1 && cnt < 2000)
    begin
      @(negedge clock);
      cnt++;
    end
    cnt = 0;
    while (k < n && cnt < 4000)
    begin
      @(negedge clock);
      cnt++;
      if (divided_sys_clk === 1'b1)
        k++;
    end
  endtask : span

  task automatic wait_lock();
    while (pll_locked !== 1'b1 && cycles - t0 < 2100)
      @(negedge clock);
    chk_bit("pll_locked", 1'b1, pll_locked);
    chk_num("lock_delay", `MPLL_SETTLE_CYC + 1, cycles - t0, 1);
  endtask : wait_lock

  task automatic set_mult(input int im, input int fm);
    @(negedge clock);
    main_pll_int_mult = im[`MPLL_INT_W-1:0];
    main_pll_frac_mult = fm[`MPLL_FRAC_W-1:0];
    t0 = cycles;
  endtask : set_mult

  task automatic t_pins();
    ref_run = 1'b0;
    fast_run = 1'b0;
    for (int v = 0; v < 2; v++)
    begin
      @(negedge clock);
      primary_clk_pin = v[0];
      aux_clk_input = ~v[0];
      internal_fast_osc_clk = ~v[0];
      internal_slow_osc_clk = v[0];
      repeat (6) @(negedge clock);
      chk_bit("osc_ref_clk", v[0], osc_ref_clk);
      chk_bit("usb_pll_ref_clk", ~v[0], usb_pll_ref_clk);
      chk_bit("can_clk", ~v[0], can_clk);
      chk_bit("lp_fast_clk", ~v[0], lp_fast_clk);
      chk_bit("lp_slow_clk", v[0], lp_slow_clk);
    end
  endtask : t_pins

  task automatic t_bypass();
    int sel [3] = '{0, 1, 3};
    ref_run = 1'b1;
    fast_run = 1'b1;
    foreach (sel[i])
    begin
      sys_div_select = sel[i][`MPLL_DIV_W-1:0];
      span(1, c);
      span(2, c);
      chk_num("bypass_span", 16 * (sel[i] + 1), c, 0);
    end
    chk_bit("missing_clk", 1'b0, missing_clk);
    chk_bit("pll_locked", 1'b0, pll_locked);
  endtask : t_bypass

  task automatic t_lock();
    sys_div_select = 6'h00;
    // The x4 and x4.5 settings keep the scaled loop below one tick per clock; the x63 setting saturates it at the cap.
    set_mult(4, 0);
    span(2, c);
    chk_num("settle_span", 16, c, 0);
    while (cycles - t0 < 1995)
      @(negedge clock);
    chk_bit("pll_locked", 1'b0, pll_locked);
    wait_lock();
    span(4, c);
    chk_num("x4_span", 16, c, 1);
    set_mult(4, 2);
    repeat (2) @(negedge clock);
    chk_bit("pll_locked", 1'b0, pll_locked);
    wait_lock();
    sys_div_select = 6'h04;
    span(1, c);
    span(5, c);
    chk_num("x4p5_span", 89, c, 2);
    set_mult(0, 2);
    repeat (2) @(negedge clock);
    chk_bit("pll_locked", 1'b0, pll_locked);
    span(1, c);
    span(2, c);
    chk_num("bypass_span", 80, c, 0);
    set_mult(63, 0);
    wait_lock();
    sys_div_select = 6'h00;
    span(1, c);
    span(4, c);
    chk_num("x63_span", 8, c, 1);
    set_mult(0, 0);
  endtask : t_lock

  task automatic t_missing();
    @(negedge clock);
    ref_run = 1'b0;
    c = 0;
    while (missing_clk !== 1'b1 && c < 80)
    begin
      @(negedge clock);
      c++;
    end
    chk_bit("missing_clk", 1'b1, missing_clk);
    ref_run = 1'b1;
    c = 0;
    while (missing_clk !== 1'b0 && c < 40)
    begin
      @(negedge clock);
      c++;
    end
    chk_bit("missing_clk", 1'b0, missing_clk);
  endtask : t_missing

  initial
  begin
    bad_count = 0;
    n_checks = 0;
    cycles = 0;
    ref_cnt = 0;
    fast_cnt = 0;
    t0 = 0;
    c = 0;
    ref_run = 1'b0;
    fast_run = 1'b0;
    rst = 1'b1;
    primary_clk_pin = 1'b0;
    aux_clk_input = 1'b0;
    internal_fast_osc_clk = 1'b0;
    internal_slow_osc_clk = 1'b0;
    main_pll_int_mult = 7'h00;
    main_pll_frac_mult = 2'h0;
    sys_div_select = 6'h00;
    repeat (5) @(negedge clock);
    chk_bit("divided_sys_clk", 1'b0, divided_sys_clk);
    chk_bit("pll_locked", 1'b0, pll_locked);
    chk_bit("missing_clk", 1'b0, missing_clk);
    rst = 1'b0;
    t_pins();
    t_bypass();
    t_lock();
    t_missing();
    end_of_test();
  end
endmodule : main_pll_clock_generation_test
